// [rtl/stiu_pkg.sv]
// Constants, types and helpers of the sensor threshold interrupt unit.
// Assumes a byte-wide register map reached over an I2C slave.
package stiu_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL    = 8'h89;
    localparam logic [7:0] ADDR_LOW_HIGH   = 8'h8A;
    localparam logic [7:0] ADDR_LOW_LOW    = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_HIGH  = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_LOW   = 8'h8D;
    localparam logic [7:0] ADDR_FLAGS      = 8'h8E;

    localparam int LIMIT_SOURCE_SELECT_BIT  = 0;
    localparam int LIMIT_IRQ_ENABLE_BIT     = 1;
    localparam int AMB_DONE_IRQ_ENABLE_BIT  = 2;
    localparam int BIO_DONE_IRQ_ENABLE_BIT  = 3;
    localparam int PERSIST_LSB              = 5;
    localparam int PERSIST_MSB              = 7;

    localparam int ABOVE_LIMIT_FLAG_BIT     = 0;
    localparam int BELOW_LIMIT_FLAG_BIT     = 1;
    localparam int AMB_DONE_FLAG_BIT        = 2;
    localparam int BIO_DONE_FLAG_BIT        = 3;
    localparam int FLAG_W                   = 4;

    localparam logic [7:0]        CONTROL_RESET  = 8'h00;
    localparam logic [7:0]        CONTROL_MASK   = 8'hEF;
    localparam logic [15:0]       LIMIT_RESET    = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAGS_RESET    = 4'h0;
    localparam logic [7:0]        READ_UNMAPPED  = 8'h00;

    // ****************************************
    // Serial link
    // ****************************************
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WDATA    = 3'h2,
        ST_WACK     = 3'h6,
        ST_RDATA    = 3'h7,
        ST_RACK     = 3'h5
    } stiu_link_state_e;

    typedef struct packed {
        logic        bio;
        logic [15:0] value;
    } stiu_meas_s;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] persist_count(input logic [2:0] code);
        persist_count = 8'h01 << code;
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0]        addr,
                                            input logic [7:0]        control,
                                            input logic [15:0]       low,
                                            input logic [15:0]       high,
                                            input logic [FLAG_W-1:0] flags);
        case (addr)
            ADDR_CONTROL:   reg_read = control;
            ADDR_LOW_HIGH:  reg_read = low[15:8];
            ADDR_LOW_LOW:   reg_read = low[7:0];
            ADDR_HIGH_HIGH: reg_read = high[15:8];
            ADDR_HIGH_LOW:  reg_read = high[7:0];
            ADDR_FLAGS:     reg_read = {4'h0, flags};
            default:        reg_read = READ_UNMAPPED;
        endcase
    endfunction

endpackage

// [rtl/stiu_meas_cdc.sv]
// Toggle handshake carrying finished results from the measurement clock.
// Assumes done strobes are one-cycle pulses on the measurement clock.
`timescale 1ns/1ns
module stiu_meas_cdc (
    input  wire logic               clk_meas_in,
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic               bio_done_in,
    input  wire logic               amb_done_in,
    input  wire logic [15:0]        result_in,
    output logic                    meas_valid_out,
    output stiu_pkg::stiu_meas_s    meas_out
);

    // ****************************************
    // Measurement side
    // ****************************************
    logic                 req_q;
    logic                 ack_m_q;
    logic                 ack_s_q;
    logic                 meas_ack_q;
    stiu_pkg::stiu_meas_s hold_q;
    logic                 busy;

    assign busy = req_q ^ ack_s_q;

    always_ff @(posedge clk_meas_in or posedge rst_in) begin
        if (rst_in) begin
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            ack_m_q <= meas_ack_q;
            ack_s_q <= ack_m_q;
        end
    end

    // Biosensor wins a tie; results while busy are dropped
    always_ff @(posedge clk_meas_in or posedge rst_in) begin
        if (rst_in) begin
            req_q  <= 1'b0;
            hold_q <= '0;
        end else if ((bio_done_in || amb_done_in) && !busy) begin
            req_q        <= ~req_q;
            hold_q.bio   <= bio_done_in;
            hold_q.value <= result_in;
        end
    end

    // ****************************************
    // System side
    // ****************************************
    logic req_m_q;
    logic req_s_q;
    logic req_d_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
            req_d_q <= 1'b0;
        end else begin
            req_m_q <= req_q;
            req_s_q <= req_m_q;
            req_d_q <= req_s_q;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            meas_valid_out <= 1'b0;
            meas_out       <= '0;
            meas_ack_q     <= 1'b0;
        end else begin
            meas_valid_out <= req_s_q ^ req_d_q;
            meas_ack_q     <= req_s_q;
            if (req_s_q ^ req_d_q) begin
                meas_out <= hold_q;
            end
        end
    end

endmodule

// [rtl/stiu_top.sv]
// I2C register slave, limit comparison and sticky flags driving the interrupt pad.
// Assumes open-drain pins resolved outside; results come from the measurement clock.
`timescale 1ns/1ns
module stiu_top #(
    parameter logic [6:0] DEV_ADDR = 7'h13
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_IN,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    output logic             INT_OUT,
    output logic             INT_OE_OUT,
    input  wire logic        MEAS_CLK_IN,
    input  wire logic        BIO_DONE_IN,
    input  wire logic        AMB_DONE_IN,
    input  wire logic [15:0] RESULT_IN
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_m_q;
    logic scl_q;
    logic scl_d_q;
    logic sda_m_q;
    logic sda_q;
    logic sda_d_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            scl_m_q <= 1'b1;
            scl_q   <= 1'b1;
            scl_d_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_q   <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_m_q <= SCL_IN;
            scl_q   <= scl_m_q;
            scl_d_q <= scl_q;
            sda_m_q <= SDA_IN;
            sda_q   <= sda_m_q;
            sda_d_q <= sda_q;
        end
    end

    assign scl_rise   = scl_q & ~scl_d_q;
    assign scl_fall   = ~scl_q & scl_d_q;
    assign start_seen = scl_q & scl_d_q & sda_d_q & ~sda_q;
    assign stop_seen  = scl_q & scl_d_q & ~sda_d_q & sda_q;

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]                  control_q;
    logic [15:0]                 low_q;
    logic [15:0]                 high_q;
    logic [stiu_pkg::FLAG_W-1:0] flags_q;
    logic [7:0]                  rd_byte;

    // ****************************************
    // I2C slave
    // ****************************************
    stiu_pkg::stiu_link_state_e state_q;
    logic [3:0]                 bit_cnt_q;
    logic [7:0]                 shift_q;
    logic [7:0]                 ptr_q;
    logic                       rw_q;
    logic                       first_q;
    logic                       sda_oe_q;
    logic                       wr_en_q;
    logic [7:0]                 wr_addr_q;
    logic [7:0]                 wr_data_q;

    assign rd_byte = stiu_pkg::reg_read(ptr_q, control_q, low_q, high_q, flags_q);

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q   <= stiu_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            sda_oe_q  <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (start_seen) begin
                state_q   <= stiu_pkg::ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end else if (stop_seen) begin
                state_q  <= stiu_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    stiu_pkg::ST_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    stiu_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == stiu_pkg::BYTE_BITS) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rw_q     <= shift_q[0];
                                sda_oe_q <= 1'b1;
                                state_q  <= stiu_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= stiu_pkg::ST_IDLE;
                            end
                        end
                    end
                    stiu_pkg::ST_WDATA: begin
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == stiu_pkg::BYTE_BITS) begin
                            if (first_q) begin
                                ptr_q <= shift_q;
                            end else begin
                                wr_en_q   <= 1'b1;
                                wr_addr_q <= ptr_q;
                                wr_data_q <= shift_q;
                                ptr_q     <= ptr_q + 8'h01;
                            end
                            first_q  <= 1'b0;
                            sda_oe_q <= 1'b1;
                            state_q  <= stiu_pkg::ST_WACK;
                        end
                    end
                    stiu_pkg::ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe_q  <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q   <= stiu_pkg::ST_WDATA;
                        end
                    end
                    stiu_pkg::ST_ADDR_ACK, stiu_pkg::ST_RACK: begin
                        if (scl_rise && state_q == stiu_pkg::ST_RACK && sda_q) begin
                            state_q <= stiu_pkg::ST_IDLE;
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rw_q) begin
                                shift_q  <= rd_byte;
                                sda_oe_q <= ~rd_byte[7];
                                ptr_q    <= ptr_q + 8'h01;
                                state_q  <= stiu_pkg::ST_RDATA;
                            end else begin
                                sda_oe_q <= 1'b0;
                                first_q  <= 1'b1;
                                state_q  <= stiu_pkg::ST_WDATA;
                            end
                        end
                    end
                    stiu_pkg::ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == stiu_pkg::BYTE_BITS) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= stiu_pkg::ST_RACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= ~shift_q[6];
                            end
                        end
                    end
                    default: begin
                        state_q  <= stiu_pkg::ST_IDLE;
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Control and limit registers
    // ****************************************
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            control_q <= stiu_pkg::CONTROL_RESET;
            low_q     <= stiu_pkg::LIMIT_RESET;
            high_q    <= stiu_pkg::LIMIT_RESET;
        end else if (wr_en_q) begin
            case (wr_addr_q)
                stiu_pkg::ADDR_CONTROL:   control_q    <= wr_data_q & stiu_pkg::CONTROL_MASK;
                stiu_pkg::ADDR_LOW_HIGH:  low_q[15:8]  <= wr_data_q;
                stiu_pkg::ADDR_LOW_LOW:   low_q[7:0]   <= wr_data_q;
                stiu_pkg::ADDR_HIGH_HIGH: high_q[15:8] <= wr_data_q;
                stiu_pkg::ADDR_HIGH_LOW:  high_q[7:0]  <= wr_data_q;
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Measurement crossing and comparison
    // ****************************************
    logic                 meas_valid;
    stiu_pkg::stiu_meas_s meas;
    logic                 sel_valid;
    logic                 is_above;
    logic                 is_below;
    logic                 out_range;
    logic                 limit_en;
    logic [7:0]           cnt_q;
    logic [7:0]           cnt_next;
    logic [7:0]           persist_n;
    logic                 fire;

    stiu_meas_cdc u_cdc (
        .clk_meas_in    (MEAS_CLK_IN),
        .clk_sys_in     (CLK_SYS_IN),
        .rst_in         (RST_IN),
        .bio_done_in    (BIO_DONE_IN),
        .amb_done_in    (AMB_DONE_IN),
        .result_in      (RESULT_IN),
        .meas_valid_out (meas_valid),
        .meas_out       (meas)
    );

    assign limit_en  = control_q[stiu_pkg::LIMIT_IRQ_ENABLE_BIT];
    assign sel_valid = meas_valid && (meas.bio != control_q[stiu_pkg::LIMIT_SOURCE_SELECT_BIT]);
    assign is_above  = meas.value > high_q;
    assign is_below  = meas.value < low_q;
    assign out_range = is_above | is_below;
    assign cnt_next  = cnt_q + 8'h01;
    assign persist_n = stiu_pkg::persist_count(control_q[stiu_pkg::PERSIST_MSB:stiu_pkg::PERSIST_LSB]);
    assign fire      = limit_en && sel_valid && out_range && (cnt_next >= persist_n);

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cnt_q <= 8'h00;
        end else if (!limit_en) begin
            cnt_q <= 8'h00;
        end else if (sel_valid) begin
            if (!out_range || fire) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_next;
            end
        end
    end

    // ****************************************
    // Sticky flags and interrupt pad
    // ****************************************
    logic [stiu_pkg::FLAG_W-1:0] set_mask;
    logic [stiu_pkg::FLAG_W-1:0] clr_mask;
    logic                        int_oe_q;
    logic                        int_out_q;
    logic                        sda_out_q;

    always_comb begin
        set_mask = stiu_pkg::FLAGS_RESET;
        set_mask[stiu_pkg::ABOVE_LIMIT_FLAG_BIT] = fire & is_above;
        set_mask[stiu_pkg::BELOW_LIMIT_FLAG_BIT] = fire & is_below;
        set_mask[stiu_pkg::BIO_DONE_FLAG_BIT] = meas_valid & meas.bio &
            control_q[stiu_pkg::BIO_DONE_IRQ_ENABLE_BIT];
        set_mask[stiu_pkg::AMB_DONE_FLAG_BIT] = meas_valid & ~meas.bio &
            control_q[stiu_pkg::AMB_DONE_IRQ_ENABLE_BIT];
    end

    assign clr_mask = (wr_en_q && wr_addr_q == stiu_pkg::ADDR_FLAGS) ?
                      wr_data_q[stiu_pkg::FLAG_W-1:0] : stiu_pkg::FLAGS_RESET;

    // Set wins over a same-cycle clear
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            flags_q <= stiu_pkg::FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~clr_mask) | set_mask;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            int_oe_q  <= 1'b0;
            int_out_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            int_oe_q  <= |flags_q;
            int_out_q <= 1'b0;
            sda_out_q <= 1'b0;
        end
    end

    assign INT_OE_OUT = int_oe_q;
    assign INT_OUT    = int_out_q;
    assign SDA_OE_OUT = sda_oe_q;
    assign SDA_OUT    = sda_out_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    pad_low_a: assert property ((flags_q != 4'h0) [*2] |-> INT_OE_OUT)
        else $error("pad not pulled low while flags set");
    pad_free_a: assert property ((flags_q == 4'h0) [*2] |-> !INT_OE_OUT)
        else $error("pad pulled low with no flag set");
    flag_sticky_a: assert property (($past(flags_q) & ~flags_q & ~$past(clr_mask)) == 4'h0)
        else $error("flag dropped without a clearing write");
    flag_clear_a: assert property ((clr_mask[stiu_pkg::ABOVE_LIMIT_FLAG_BIT] &&
        !set_mask[stiu_pkg::ABOVE_LIMIT_FLAG_BIT]) |=> !flags_q[stiu_pkg::ABOVE_LIMIT_FLAG_BIT])
        else $error("write of one did not clear flag");
    above_set_a: assert property (fire && is_above |=>
        flags_q[stiu_pkg::ABOVE_LIMIT_FLAG_BIT]) else $error("above flag not set");
    below_set_a: assert property (fire && is_below |=>
        flags_q[stiu_pkg::BELOW_LIMIT_FLAG_BIT]) else $error("below flag not set");
    persist_a: assert property (fire && cnt_q < persist_n |-> cnt_next == persist_n)
        else $error("interrupt at wrong persistence count");
    range_reset_a: assert property (sel_valid && !out_range |=> cnt_q == 8'h00)
        else $error("counter not restarted inside limits");
    limit_gate_a: assert property (!limit_en |-> !fire ##1 !$rose(flags_q[0]))
        else $error("threshold interrupt while disabled");
    source_sel_a: assert property (fire |->
        meas.bio == !control_q[stiu_pkg::LIMIT_SOURCE_SELECT_BIT])
        else $error("threshold applied to wrong channel");
    done_flag_a: assert property (meas_valid && meas.bio &&
        control_q[stiu_pkg::BIO_DONE_IRQ_ENABLE_BIT] |=> flags_q[stiu_pkg::BIO_DONE_FLAG_BIT])
        else $error("biosensor done flag not set");
    low_write_a: assert property (wr_en_q && wr_addr_q == stiu_pkg::ADDR_LOW_HIGH |=>
        low_q[15:8] == $past(wr_data_q)) else $error("low limit high byte not written");
    high_write_a: assert property (wr_en_q && wr_addr_q == stiu_pkg::ADDR_HIGH_LOW |=>
        high_q[7:0] == $past(wr_data_q)) else $error("high limit low byte not written");
    ctrl_write_a: assert property (wr_en_q && wr_addr_q == stiu_pkg::ADDR_CONTROL |=>
        control_q == ($past(wr_data_q) & stiu_pkg::CONTROL_MASK))
        else $error("control byte not written");
    status_read_a: assert property (state_q == stiu_pkg::ST_ADDR_ACK && rw_q && scl_fall &&
        ptr_q == stiu_pkg::ADDR_FLAGS && !start_seen && !stop_seen |=>
        shift_q == {4'h0, $past(flags_q)}) else $error("status byte read wrong");

endmodule

// [bench/stiu_host.sv]
// Host model: a bit-level I2C master that drives SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up; the clock stands high between frames.
`timescale 1ns/1ns
module stiu_host (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    // Start or repeated start when low, stop when high
    task automatic cond(input logic stop);
        sda_oe_out = stop;
        tick(4);
        scl_out = 1'b1;
        tick(5);
        sda_oe_out = ~stop;
        tick(5);
        scl_out = stop;
    endtask
    // Nine bits MSB first; a 1 releases SDA so the device may answer
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            tick(3);
            sda_oe_out = ~d[i];
            tick(4);
            scl_out = 1'b1;
            tick(3);
            q[i] = sda_in;
            tick(2);
            scl_out = 1'b0;
        end
    endtask
endmodule

// [bench/tb.sv]
// Bench top: drives the unit through the host model and the result link.
// Assumes the default device address and the package register map.
`timescale 1ns/1ns
module tb;
    logic        clk;
    logic        rst;
    logic        mclk;
    logic        bio;
    logic        amb;
    logic [15:0] res;
    logic        sda_o;
    logic        int_o;
    logic        scl;
    logic        h_oe;
    logic        sda_oe;
    logic        int_oe;
    int          error_cnt = 0;
    int          total_checks = 0;
    wire logic   sda = ~(h_oe | sda_oe);
    stiu_host i_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe));
    stiu_top i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe), .INT_OUT(int_o), .INT_OE_OUT(int_oe), .MEAS_CLK_IN(mclk),
        .BIO_DONE_IN(bio), .AMB_DONE_IN(amb), .RESULT_IN(res));
    always #10 clk = ~clk;
    initial begin
        mclk = 1'b0;
        #13;
        forever #40 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] q1;
        logic [8:0] q2;
        logic [8:0] q3;
        i_host.cond(1'b0);
        i_host.xfer({8'h26, 1'b1}, q1);
        i_host.xfer({a, 1'b1}, q2);
        i_host.xfer({d, 1'b1}, q3);
        i_host.cond(1'b1);
        chk({5'h00, q1[0], q2[0], q3[0]}, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] q;
        i_host.cond(1'b0);
        i_host.xfer({8'h26, 1'b1}, q);
        i_host.xfer({a, 1'b1}, q);
        i_host.cond(1'b0);
        i_host.xfer({8'h27, 1'b1}, q);
        i_host.xfer({8'hFF, 1'b1}, q);
        i_host.cond(1'b1);
        chk(q[8:1], e);
    endtask
    // One result on the link clock; the word is scrambled once the strobe drops
    task automatic meas(input logic b, input logic [15:0] v);
        @(posedge mclk);
        #2;
        {bio, amb, res} = {b, ~b, v};
        @(posedge mclk);
        #2;
        {bio, amb, res} = {2'h0, ~v};
        repeat (10) @(posedge mclk);
    endtask
    task automatic t_regs;
        logic [8:0] q;
        rd(8'h89, 8'h00);
        rd(8'h8E, 8'h00);
        wr(8'h89, 8'hFF);
        rd(8'h89, 8'hEF);
        wr(8'h8A, 8'h01);
        wr(8'h8B, 8'h10);
        wr(8'h8C, 8'h02);
        wr(8'h8D, 8'h00);
        rd(8'h8B, 8'h10);
        rd(8'h8C, 8'h02);
        rd(8'h90, 8'h00);
        i_host.cond(1'b0);
        i_host.xfer({8'h30, 1'b1}, q);
        i_host.cond(1'b1);
        chk({7'h00, q[0]}, 8'h01);
        chk({6'h00, sda_o, int_o}, 8'h00);
    endtask
    task automatic t_persist;
        for (int c = 0; c < 8; c++) begin
            wr(8'h89, {c[2:0], 5'h02});
            repeat ((1 << c) - 1) meas(1'b1, 16'h0300);
            rd(8'h8E, 8'h00);
            meas(1'b1, 16'h0300);
            rd(8'h8E, 8'h01);
            chk({7'h00, int_oe}, 8'h01);
            wr(8'h8E, 8'h01);
        end
        wr(8'h89, 8'h22);
        meas(1'b1, 16'h0300);
        meas(1'b1, 16'h0150);
        meas(1'b1, 16'h0300);
        meas(1'b0, 16'h0150);
        rd(8'h8E, 8'h00);
        meas(1'b1, 16'h0300);
        rd(8'h8E, 8'h01);
        wr(8'h8E, 8'h01);
        chk({7'h00, int_oe}, 8'h00);
    endtask
    task automatic t_low;
        wr(8'h89, 8'h0F);
        meas(1'b0, 16'h0050);
        rd(8'h8E, 8'h06);
        meas(1'b1, 16'h0050);
        rd(8'h8E, 8'h0E);
        wr(8'h8E, 8'h04);
        rd(8'h8E, 8'h0A);
        wr(8'h89, 8'h01);
        wr(8'h8E, 8'h0F);
        meas(1'b0, 16'h0050);
        rd(8'h8E, 8'h00);
        chk({7'h00, int_oe}, 8'h00);
    endtask
    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {bio, amb, res} = 18'h00000;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        t_regs();
        t_persist();
        t_low();
        finish_test();
    end
    initial begin
        #1500000;
        error_cnt++;
        $display("Error at %0t: run timed out", $time);
        finish_test();
    end
endmodule
